// >>> common/scr_regs.svh
// Register offsets, field positions and reset values of the serial channel router
`ifndef SCR_REGS_SVH
`define SCR_REGS_SVH
`define SCR_MODE_OFF 12'h8b0
`define SCR_MASK_OFF 12'h8b2
`define SCR_STAT_OFF 12'h8b4
`define SCR_MODE_RST 16'h0000
`define SCR_MASK_RST 16'hffff
`define SCR_MS_LSB 0
`define SCR_CTRL_TWO_DETACH_BIT 2
`define SCR_CTRL_THREE_DETACH_BIT 3
`define SCR_DR_LSB 4
`define SCR_B1R_LSB 6
`define SCR_B2R_LSB 8
`define SCR_STROBE_CTRL_B1_BIT 10
`define SCR_STROBE_CTRL_B2_BIT 11
`define SCR_SLOT_BITS 8
`define SCR_D_BITS 2
`endif

// >>> common/scr_pkg.sv
// Types of the serial channel router
package scr_pkg;
  typedef enum logic [1:0] {SCR_NONMULTIPLEXED_SERIAL_MODE_MODE, SCR_PCM_MODE, SCR_IDL_MODE, SCR_GCI_MODE} scr_mode_t;
  typedef enum logic [1:0] {SCR_NONE, SCR_CTRL1, SCR_CTRL2, SCR_CTRL3} scr_route_t;
  typedef enum {SCR_SLOT_IDLE, SCR_SLOT_B1, SCR_SLOT_B2, SCR_SLOT_D} scr_slot_t;
  typedef struct packed
  {
    logic strobe_ctrl_b2;
    logic strobe_ctrl_b1;
    scr_route_t b2_route_field;
    scr_route_t b1_route_field;
    scr_route_t d_route_field;
    logic ctrl_three_detach;
    logic ctrl_two_detach;
    scr_mode_t interface_mode_field;
  } scr_cfg_t;
  typedef struct packed
  {
    logic [2:0] rx_valid;
    logic [2:0] rx_data;
  } scr_lane_t;
endpackage

// >>> rtl/scr_router.sv
// Serial channel router: mode, channel routing, strobes and bit mask
// What this block does
// R1 - Strobe bit b2: 0 strobe two, 1 strobe one
// R2 - Strobe bit b1: 0 strobe one, 1 strobe two
// R3 - B2 route: none, ctrl one, two, three
// R4 - B1 route: none, ctrl one, two, three
// R5 - D route: none, ctrl one, two, three
// R6 - Routes to detached controllers deliver nothing
// R7 - Detach bit three detaches controller three
// R8 - Detach bit two detaches controller two
// R9 - Mode field: nonmux, PCM, digital link, GCI
// R10 - 16-bit mask: upper B2 bits, lower B1
// R11 - Mask bit zero is first slot bit
// R12 - Cleared mask bit in digital link and GCI modes: ignored rx, idle tx
`timescale 1ns/100ps
`include "scr_regs.svh"
module scr_router
  import scr_pkg::*;
(
  input wire logic ref_clk, // System clock, 200 MHz
  input wire logic sys_rst, // Asynchronous reset, active high
  input wire logic [13:0] s_axi_awaddr, // Write byte address
  input wire logic s_axi_awvalid, // Write address valid
  output logic s_axi_awready, // Write address ready
  input wire logic [31:0] s_axi_wdata, // Write data
  input wire logic [3:0] s_axi_wstrb, // Write byte enables
  input wire logic s_axi_wvalid, // Write data valid
  output logic s_axi_wready, // Write data ready
  output logic [1:0] s_axi_bresp, // Write response
  output logic s_axi_bvalid, // Write response valid
  input wire logic s_axi_bready, // Write response ready
  input wire logic [13:0] s_axi_araddr, // Read byte address
  input wire logic s_axi_arvalid, // Read address valid
  output logic s_axi_arready, // Read address ready
  output logic [31:0] s_axi_rdata, // Read data
  output logic [1:0] s_axi_rresp, // Read response
  output logic s_axi_rvalid, // Read data valid
  input wire logic s_axi_rready, // Read data ready
  input wire logic link_clk, // Link bit clock
  input wire logic link_sync, // Frame sync pin, high one bit clock ahead of the first B1 bit
  input wire logic link_rxd, // Serial receive pin
  output logic link_txd, // Serial transmit pin
  output logic data_strobe_one, // First data strobe output
  output logic data_strobe_two, // Second data strobe output
  input wire logic [2:0] ctrl_tx_data, // Transmit bits from controllers 1..3
  output logic [2:0] ctrl_rx_valid, // Receive bit valid per controller
  output logic [2:0] ctrl_rx_data // Receive bit per controller
);
  localparam logic [1:0] RESP_OK = 2'h0; // Okay answer
  localparam logic [1:0] RESP_ERR = 2'h2; // Slave error for unmapped addresses

  // Register state, system domain
  logic [15:0] mode_ff, nxt_mode;
  logic [15:0] mask_ff, nxt_mask;
  logic aw_got_ff, nxt_aw_got;
  logic w_got_ff, nxt_w_got;
  logic [13:0] awaddr_ff, nxt_awaddr;
  logic [31:0] wdata_ff, nxt_wdata;
  logic [3:0] wstrb_ff, nxt_wstrb;
  logic bvalid_ff, nxt_bvalid;
  logic [1:0] bresp_ff, nxt_bresp;
  logic rvalid_ff, nxt_rvalid;
  logic [31:0] rdata_ff, nxt_rdata;
  logic [1:0] rresp_ff, nxt_rresp;

  // Frame count returned from the link, crossed as a gray code
  logic [7:0] fcnt_gray_s1_ff, fcnt_gray_s2_ff;

  // Byte-lane merge used for both registers
  function automatic logic [15:0] merge16(input logic [15:0] old, input logic [31:0] d,
                                          input logic [3:0] be);
    logic [15:0] r;
    r = old;
    if (be[0])
    begin
      r[7:0] = d[7:0];
    end
    if (be[1])
    begin
      r[15:8] = d[15:8];
    end
    return r;
  endfunction

  // Register of a byte address: 0 mode, 1 mask, 2 status, 3 unmapped; offsets are
  // word indices, since the mask offset is not word aligned, so bytes are four per index
  function automatic logic [1:0] reg_sel(input logic [13:0] a);
    logic [1:0] s;
    s = 2'h3;
    case (a[13:2])
      `SCR_MODE_OFF: s = 2'h0;
      `SCR_MASK_OFF: s = 2'h1;
      `SCR_STAT_OFF: s = 2'h2;
      default: s = 2'h3;
    endcase
    return s;
  endfunction

  assign s_axi_awready = !aw_got_ff && !bvalid_ff;
  assign s_axi_wready = !w_got_ff && !bvalid_ff;
  assign s_axi_arready = !rvalid_ff;
  assign s_axi_bvalid = bvalid_ff;
  assign s_axi_bresp = bresp_ff;
  assign s_axi_rvalid = rvalid_ff;
  assign s_axi_rdata = rdata_ff;
  assign s_axi_rresp = rresp_ff;

  // Bus slave next state: address and data may come in either order
  always_comb
  begin
    logic aw_now;
    logic w_now;
    logic [13:0] wa;
    logic [31:0] wd;
    logic [3:0] wb;
    aw_now = aw_got_ff || (s_axi_awvalid && s_axi_awready);
    w_now = w_got_ff || (s_axi_wvalid && s_axi_wready);
    wa = aw_got_ff ? awaddr_ff : s_axi_awaddr;
    wd = w_got_ff ? wdata_ff : s_axi_wdata;
    wb = w_got_ff ? wstrb_ff : s_axi_wstrb;
    nxt_mode = mode_ff;
    nxt_mask = mask_ff;
    nxt_aw_got = aw_got_ff || (s_axi_awvalid && s_axi_awready);
    nxt_w_got = w_got_ff || (s_axi_wvalid && s_axi_wready);
    nxt_awaddr = (s_axi_awvalid && s_axi_awready) ? s_axi_awaddr : awaddr_ff;
    nxt_wdata = (s_axi_wvalid && s_axi_wready) ? s_axi_wdata : wdata_ff;
    nxt_wstrb = (s_axi_wvalid && s_axi_wready) ? s_axi_wstrb : wstrb_ff;
    nxt_bvalid = bvalid_ff && !s_axi_bready;
    nxt_bresp = bresp_ff;
    nxt_rvalid = rvalid_ff && !s_axi_rready;
    nxt_rdata = rdata_ff;
    nxt_rresp = rresp_ff;
    // Both halves present: commit and answer next cycle
    if (aw_now && w_now && !bvalid_ff)
    begin
      nxt_aw_got = 1'b0;
      nxt_w_got = 1'b0;
      nxt_bvalid = 1'b1;
      nxt_bresp = RESP_OK;
      if (reg_sel(wa) == 2'h0)
      begin
        nxt_mode = merge16(mode_ff, wd, wb); // [R9]
      end
      else if (reg_sel(wa) == 2'h1)
      begin
        nxt_mask = merge16(mask_ff, wd, wb); // [R10]
      end
      else if (reg_sel(wa) != 2'h2)
      begin
        nxt_bresp = RESP_ERR; // Unmapped
      end
    end
    // Read answer one cycle after the address is taken
    if (s_axi_arvalid && s_axi_arready)
    begin
      nxt_rvalid = 1'b1;
      nxt_rresp = RESP_OK;
      if (reg_sel(s_axi_araddr) == 2'h0)
      begin
        nxt_rdata = {16'h0000, mode_ff};
      end
      else if (reg_sel(s_axi_araddr) == 2'h1)
      begin
        nxt_rdata = {16'h0000, mask_ff}; // Mask owns its whole word, in the low half
      end
      else if (reg_sel(s_axi_araddr) == 2'h2)
      begin
        nxt_rdata = {24'h000000, fcnt_gray_s2_ff ^ (fcnt_gray_s2_ff >> 1)
          ^ (fcnt_gray_s2_ff >> 2) ^ (fcnt_gray_s2_ff >> 3) ^ (fcnt_gray_s2_ff >> 4)
          ^ (fcnt_gray_s2_ff >> 5) ^ (fcnt_gray_s2_ff >> 6) ^ (fcnt_gray_s2_ff >> 7)};
      end
      else
      begin
        nxt_rdata = 32'h00000000;
        nxt_rresp = RESP_ERR; // Unmapped
      end
    end
  end

  // Bus slave registers
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      mode_ff <= `SCR_MODE_RST;
      mask_ff <= `SCR_MASK_RST;
      aw_got_ff <= 1'b0;
      w_got_ff <= 1'b0;
      awaddr_ff <= 14'h0000;
      wdata_ff <= 32'h00000000;
      wstrb_ff <= 4'h0;
      bvalid_ff <= 1'b0;
      bresp_ff <= 2'h0;
      rvalid_ff <= 1'b0;
      rdata_ff <= 32'h00000000;
      rresp_ff <= 2'h0;
    end
    else
    begin
      mode_ff <= nxt_mode;
      mask_ff <= nxt_mask;
      aw_got_ff <= nxt_aw_got;
      w_got_ff <= nxt_w_got;
      awaddr_ff <= nxt_awaddr;
      wdata_ff <= nxt_wdata;
      wstrb_ff <= nxt_wstrb;
      bvalid_ff <= nxt_bvalid;
      bresp_ff <= nxt_bresp;
      rvalid_ff <= nxt_rvalid;
      rdata_ff <= nxt_rdata;
      rresp_ff <= nxt_rresp;
    end
  end

  // Configuration held steady by software while the link runs; each bit is
  // synchronised separately, so a change may apply over one frame boundary
  logic [15:0] cfg_s1_ff, cfg_s2_ff, mask_s1_ff, mask_s2_ff;
  scr_cfg_t cfg;
  always_ff @(posedge link_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      cfg_s1_ff <= `SCR_MODE_RST;
      cfg_s2_ff <= `SCR_MODE_RST;
      mask_s1_ff <= `SCR_MASK_RST;
      mask_s2_ff <= `SCR_MASK_RST;
    end
    else
    begin
      cfg_s1_ff <= mode_ff;
      cfg_s2_ff <= cfg_s1_ff;
      mask_s1_ff <= mask_ff;
      mask_s2_ff <= mask_s1_ff;
    end
  end
  assign cfg = scr_cfg_t'(cfg_s2_ff[11:0]);

  // Link pins pass two flops before use
  logic sync_s1_ff, sync_s2_ff, rxd_s1_ff, rxd_s2_ff;
  always_ff @(posedge link_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      sync_s1_ff <= 1'b0;
      sync_s2_ff <= 1'b0;
      rxd_s1_ff <= 1'b0;
      rxd_s2_ff <= 1'b0;
    end
    else
    begin
      sync_s1_ff <= link_sync;
      sync_s2_ff <= sync_s1_ff;
      rxd_s1_ff <= link_rxd;
      rxd_s2_ff <= rxd_s1_ff;
    end
  end

  // Slot sequencer: 8 bits B1, 8 bits B2, 2 bits D after each sync
  scr_slot_t slot_ff, nxt_slot;
  logic [2:0] bit_ff, nxt_bit;
  logic [7:0] fcnt_ff, nxt_fcnt;
  logic [7:0] fcnt_gray_ff;
  always_comb
  begin
    nxt_slot = slot_ff;
    nxt_bit = bit_ff + 3'h1;
    nxt_fcnt = fcnt_ff;
    if (sync_s2_ff)
    begin
      nxt_slot = SCR_SLOT_B1;
      nxt_bit = 3'h0;
      nxt_fcnt = fcnt_ff + 8'h01;
    end
    else
    begin
      case (slot_ff)
        SCR_SLOT_B1: if (bit_ff == 3'h7) nxt_slot = SCR_SLOT_B2;
        SCR_SLOT_B2: if (bit_ff == 3'h7) nxt_slot = SCR_SLOT_D;
        SCR_SLOT_D: if (bit_ff == 3'(`SCR_D_BITS - 1)) nxt_slot = SCR_SLOT_IDLE;
        SCR_SLOT_IDLE: nxt_bit = 3'h0;
        default: nxt_slot = SCR_SLOT_IDLE;
      endcase
      if (nxt_slot != slot_ff)
      begin
        nxt_bit = 3'h0;
      end
    end
  end

  // Route lookup, detach bits gate controllers two and three
  function automatic logic [2:0] route_onehot(input scr_route_t r, input scr_cfg_t c);
    logic [2:0] o;
    o = 3'h0;
    case (r)
      SCR_CTRL1: o = 3'h1;
      SCR_CTRL2: o = c.ctrl_two_detach ? 3'h0 : 3'h2; // [R6] [R8]
      SCR_CTRL3: o = c.ctrl_three_detach ? 3'h0 : 3'h4; // [R6] [R7]
      default: o = 3'h0;
    endcase
    return o;
  endfunction

  // Per-bit routing decision in this slot
  logic [2:0] dest;
  logic mask_on;
  logic muxed;
  always_comb
  begin
    muxed = cfg.interface_mode_field != SCR_NONMULTIPLEXED_SERIAL_MODE_MODE; // [R9]
    mask_on = 1'b1;
    dest = 3'h0;
    case (slot_ff)
      SCR_SLOT_B1:
      begin
        dest = route_onehot(cfg.b1_route_field, cfg); // [R4]
        if (cfg.interface_mode_field == SCR_IDL_MODE || cfg.interface_mode_field == SCR_GCI_MODE)
        begin
          mask_on = mask_s2_ff[bit_ff]; // [R10] [R11]
        end
      end
      SCR_SLOT_B2:
      begin
        dest = route_onehot(cfg.b2_route_field, cfg); // [R3]
        if (cfg.interface_mode_field == SCR_IDL_MODE || cfg.interface_mode_field == SCR_GCI_MODE)
        begin
          mask_on = mask_s2_ff[`SCR_SLOT_BITS + 32'(bit_ff)]; // [R10]
        end
      end
      SCR_SLOT_D: dest = route_onehot(cfg.d_route_field, cfg); // [R5]
      default: dest = 3'h0;
    endcase
    if (!muxed || !mask_on)
    begin
      dest = 3'h0; // [R12]
    end
  end

  // Link outputs registered on the link clock
  logic txd_ff, nxt_txd, data_strobe_one_ff, nxt_data_strobe_one, data_strobe_two_ff, nxt_data_strobe_two;
  scr_lane_t lane_ff, nxt_lane;
  always_comb
  begin
    nxt_txd = |(dest & ctrl_tx_data); // [R12] Idle low when no destination
    nxt_lane.rx_valid = dest; // [R6]
    nxt_lane.rx_data = dest & {3{rxd_s2_ff}};
    nxt_data_strobe_one = muxed && ((slot_ff == SCR_SLOT_B1 && !cfg.strobe_ctrl_b1)
      || (slot_ff == SCR_SLOT_B2 && cfg.strobe_ctrl_b2)); // [R1] [R2]
    nxt_data_strobe_two = muxed && ((slot_ff == SCR_SLOT_B2 && !cfg.strobe_ctrl_b2)
      || (slot_ff == SCR_SLOT_B1 && cfg.strobe_ctrl_b1)); // [R1] [R2]
  end

  // Link-domain registers
  always_ff @(posedge link_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      slot_ff <= SCR_SLOT_IDLE;
      bit_ff <= 3'h0;
      fcnt_ff <= 8'h00;
      fcnt_gray_ff <= 8'h00;
      txd_ff <= 1'b0;
      data_strobe_one_ff <= 1'b0;
      data_strobe_two_ff <= 1'b0;
      lane_ff <= '0;
    end
    else
    begin
      slot_ff <= nxt_slot;
      bit_ff <= nxt_bit;
      fcnt_ff <= nxt_fcnt;
      fcnt_gray_ff <= fcnt_ff ^ (fcnt_ff >> 1);
      txd_ff <= nxt_txd;
      data_strobe_one_ff <= nxt_data_strobe_one;
      data_strobe_two_ff <= nxt_data_strobe_two;
      lane_ff <= nxt_lane;
    end
  end

  // Gray frame count into the system domain
  always_ff @(posedge ref_clk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      fcnt_gray_s1_ff <= 8'h00;
      fcnt_gray_s2_ff <= 8'h00;
    end
    else
    begin
      fcnt_gray_s1_ff <= fcnt_gray_ff;
      fcnt_gray_s2_ff <= fcnt_gray_s1_ff;
    end
  end

  assign link_txd = txd_ff;
  assign data_strobe_one = data_strobe_one_ff;
  assign data_strobe_two = data_strobe_two_ff;
  assign ctrl_rx_valid = lane_ff.rx_valid;
  assign ctrl_rx_data = lane_ff.rx_data;
endmodule

// >>> verification/scr_router_chk.sv
// Port level checks of the serial channel router
`timescale 1ns/100ps
module scr_router_chk
(
  input wire logic ref_clk, // Clock
  input wire logic sys_rst, // Reset
  input wire logic s_axi_awvalid, // AW valid
  input wire logic s_axi_awready, // AW ready
  input wire logic s_axi_wvalid, // W valid
  input wire logic s_axi_wready, // W ready
  input wire logic s_axi_bvalid, // B valid
  input wire logic s_axi_bready, // B ready
  input wire logic s_axi_arvalid, // AR valid
  input wire logic s_axi_arready, // AR ready
  input wire logic s_axi_rvalid, // R valid
  input wire logic s_axi_rready, // R ready
  input wire logic [31:0] s_axi_rdata, // Read data
  input wire logic [1:0] s_axi_rresp, // Read response
  input wire logic link_clk, // Link clock
  input wire logic data_strobe_one, // Strobe one
  input wire logic data_strobe_two, // Strobe two
  input wire logic [2:0] ctrl_rx_valid // Lane valids
);
  // Bus answers and holds, system domain
  chk_wr_answer: assert property (@(posedge ref_clk) disable iff (sys_rst)
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid)
    else $error("write answer missing");
  // Held while refused and gone once taken; the bench keeps ready up, so it sees the drop
  chk_b_hold: assert property (@(posedge ref_clk) disable iff (sys_rst)
    s_axi_bvalid |=> s_axi_bvalid == !$past(s_axi_bready))
    else $error("bvalid not held or not dropped");
  chk_rd_answer: assert property (@(posedge ref_clk) disable iff (sys_rst)
    s_axi_arvalid && s_axi_arready |=> s_axi_rvalid) else $error("read answer missing");
  chk_r_hold: assert property (@(posedge ref_clk) disable iff (sys_rst)
    s_axi_rvalid |=> (s_axi_rvalid == !$past(s_axi_rready))
    && ($past(s_axi_rready) || $stable(s_axi_rdata)))
    else $error("read data not held or not dropped");
  chk_err_zero: assert property (@(posedge ref_clk) disable iff (sys_rst)
    s_axi_rvalid && s_axi_rresp == 2'b10 |-> s_axi_rdata == 32'h0)
    else $error("error read carries data");
  // Link domain: one lane per bit, strobes never overlap, strobe two lasts at least a slot
  chk_route_one: assert property (@(posedge link_clk) disable iff (sys_rst)
    $onehot0(ctrl_rx_valid)) else $error("bit routed to two lanes");
  chk_strobe_apart: assert property (@(posedge link_clk) disable iff (sys_rst)
    !(data_strobe_one && data_strobe_two)) else $error("both strobes high");
  chk_strobe_len: assert property (@(posedge link_clk) disable iff (sys_rst)
    $rose(data_strobe_two) |-> data_strobe_two [*8]) else $error("strobe two too short");
  cover property (@(posedge ref_clk) s_axi_bvalid && s_axi_bready);
  cover property (@(posedge ref_clk) s_axi_rvalid && s_axi_rresp == 2'b10);
  cover property (@(posedge link_clk) ctrl_rx_valid[2]);
endmodule
bind scr_router scr_router_chk i_scr_router_chk (.ref_clk, .sys_rst, .s_axi_awvalid,
  .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid,
  .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_rresp, .link_clk,
  .data_strobe_one, .data_strobe_two, .ctrl_rx_valid);

// >>> verification/scr_line_model.sv
// Line interface model: gated link clock, frame sync and bit counters
`timescale 1ns/100ps
module scr_line_model
(
  output logic link_clk, // Link clock, still between frames
  output logic link_sync, // Frame sync pulse
  output logic link_rxd, // Receive line
  input wire logic link_txd, // Transmit line
  input wire logic data_strobe_one, // Strobe one
  input wire logic data_strobe_two, // Strobe two
  input wire logic [2:0] ctrl_rx_valid, // Lane valids
  input wire logic [2:0] ctrl_rx_data // Lane bits
);
  int cnt_s1, cnt_s2, cnt_tx, cnt_v[3], cnt_d[3]; // Counts of the last run
  initial
  begin
    link_clk = 1'b0;
    link_sync = 1'b0;
    link_rxd = 1'b1;
  end
  // Run n clocks with sync in clock s; sampling mid high phase avoids edge races
  task automatic run(input int n, input int s, input logic bv);
    cnt_s1 = 0;
    cnt_s2 = 0;
    cnt_tx = 0;
    cnt_v = '{0, 0, 0};
    cnt_d = '{0, 0, 0};
    for (int i = 0; i < n; i++)
    begin
      link_sync = (i == s);
      link_rxd = bv;
      #16 link_clk = 1'b1;
      #8 cnt_s1 += (data_strobe_one === 1'b1);
      cnt_s2 += (data_strobe_two === 1'b1);
      cnt_tx += (link_txd === 1'b1);
      for (int k = 0; k < 3; k++)
      begin
        cnt_v[k] += (ctrl_rx_valid[k] === 1'b1);
        cnt_d[k] += (ctrl_rx_valid[k] === 1'b1 && ctrl_rx_data[k] === 1'b1);
      end
      #8 link_clk = 1'b0;
    end
    // Released line shows the inverse so a stale bit cannot pass as data
    link_sync = 1'b0;
    link_rxd = ~bv;
  endtask
endmodule

// >>> verification/tb_top.sv
// Self-checking bench of the serial channel router
`timescale 1ns/100ps
`include "scr_regs.svh"
module tb_top;
  logic ref_clk, sys_rst, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic [13:0] s_axi_awaddr, s_axi_araddr; // Byte addresses
  logic [31:0] s_axi_wdata, s_axi_rdata; // Data
  logic [3:0] s_axi_wstrb; // Byte enables
  logic [1:0] s_axi_bresp, s_axi_rresp; // Responses
  logic link_clk, link_sync, link_rxd, link_txd, data_strobe_one, data_strobe_two;
  logic [2:0] ctrl_tx_data, ctrl_rx_valid, ctrl_rx_data; // Controller lanes
  int mismatches, checks; // Report counters
  // Offsets are word indices, since the mask offset is not word aligned
  localparam logic [13:0] MODE_BYTE = {`SCR_MODE_OFF, 2'b00}; // Mode word
  localparam logic [13:0] MASK_BYTE = {`SCR_MASK_OFF, 2'b00}; // Mask word
  localparam logic [13:0] STAT_BYTE = {`SCR_STAT_OFF, 2'b00}; // Frame count word
  scr_router i_scr_router (.ref_clk, .sys_rst, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready, .link_clk, .link_sync, .link_rxd, .link_txd,
    .data_strobe_one, .data_strobe_two, .ctrl_tx_data, .ctrl_rx_valid, .ctrl_rx_data);
  scr_line_model i_scr_line_model (.link_clk, .link_sync, .link_rxd, .link_txd,
    .data_strobe_one, .data_strobe_two, .ctrl_rx_valid, .ctrl_rx_data);
  initial
  begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic cmp_reg(string nm, logic [31:0] exp, logic [31:0] got);
    checks++;
    if (got !== exp)
    begin
      mismatches++;
      $display("[ERR] %s exp %h got %h", nm, exp, got);
    end
  endtask
  task automatic cmp_cnt(string nm, int exp, int got);
    checks++;
    if (got != exp)
    begin
      mismatches++;
      $display("[ERR] %s exp %0d got %0d", nm, exp, got);
    end
  endtask
  // Master write: both halves offered together, each dropped once taken
  task automatic axi_wr(logic [13:0] a, logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge ref_clk);
    {s_axi_awaddr, s_axi_wdata, s_axi_wstrb} <= {a, d, 4'hf};
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
    for (n = 0; n < 40 && s_axi_bvalid !== 1'b1; n++)
    begin
      @(posedge ref_clk);
      if (s_axi_awready === 1'b1)
        s_axi_awvalid <= 1'b0;
      if (s_axi_wready === 1'b1)
        s_axi_wvalid <= 1'b0;
    end
    if (n == 40)
      cmp_reg("write answer", 1, 0);
    if (n == 40)
      give_verdict();
    r = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask
  task automatic axi_rd(logic [13:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge ref_clk);
    s_axi_araddr <= a;
    {s_axi_arvalid, s_axi_rready} <= 2'b11;
    for (n = 0; n < 40 && s_axi_rvalid !== 1'b1; n++)
    begin
      @(posedge ref_clk);
      if (s_axi_arready === 1'b1)
        s_axi_arvalid <= 1'b0;
    end
    if (n == 40)
      cmp_reg("read answer", 1, 0);
    if (n == 40)
      give_verdict();
    {d, r} = {s_axi_rdata, s_axi_rresp};
    s_axi_rready <= 1'b0;
  endtask
  function automatic logic [31:0] lfsr(logic [31:0] x);
    return {x[30:0], 1'b0} ^ (x[31] ? 32'h04c11db7 : 32'h0);
  endfunction
  // Controller index that receives a route code, -1 for none or detached
  function automatic int dest(int rt, logic [31:0] c);
    if (rt == 2 && !c[`SCR_CTRL_TWO_DETACH_BIT]) return 1;
    if (rt == 3 && !c[`SCR_CTRL_THREE_DETACH_BIT]) return 2;
    return (rt == 1) ? 0 : -1;
  endfunction
  initial
  begin
    logic [1:0] rs;
    logic [31:0] rd, cfg, mk, rnd;
    int e[3], s1, m, k, r1, r2, n1, n2, etx;
    logic [2:0] tx; // Controller transmit bits of this frame
    logic bv; // Receive line level of this frame
    {sys_rst, s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 6'h20;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata, s_axi_wstrb} = '0;
    ctrl_tx_data = 3'b111;
    rnd = 32'hda64;
    // Reset spans link edges too, so the link side clears as well
    i_scr_line_model.run(2, -1, 1'b0);
    @(posedge ref_clk) sys_rst <= 1'b0;
    axi_rd(MODE_BYTE, rd, rs);
    cmp_reg("mode reset", `SCR_MODE_RST, rd);
    axi_rd(MASK_BYTE, rd, rs);
    cmp_reg("mask reset", `SCR_MASK_RST, rd);
    axi_rd(STAT_BYTE, rd, rs);
    cmp_reg("frame count reset", 0, rd);
    axi_wr(14'h0010, 32'hffff, rs);
    cmp_reg("unmapped wr", 2'b10, rs);
    axi_rd(14'h0010, rd, rs);
    cmp_reg("unmapped rd data", 0, rd);
    cmp_reg("unmapped rd resp", 2'b10, rs);
    for (int i = 0; i < 16; i++)
    begin
      rnd = lfsr(rnd);
      mk = rnd[15:0];
      {m, r1, r2} = {i % 4, (i + 1) % 4, (i + 3) % 4};
      cfg = m | (rnd[25:24] << `SCR_CTRL_TWO_DETACH_BIT) | ((i / 4) << `SCR_DR_LSB);
      cfg |= (r1 << `SCR_B1R_LSB) | (r2 << `SCR_B2R_LSB) | (rnd[27:26] << `SCR_STROBE_CTRL_B1_BIT);
      axi_wr(MASK_BYTE, mk, rs);
      cmp_reg("mask wr resp", 0, rs);
      axi_rd(MASK_BYTE, rd, rs);
      cmp_reg("mask", mk, rd);
      axi_wr(MODE_BYTE, cfg, rs);
      axi_rd(MODE_BYTE, rd, rs);
      cmp_reg("mode", cfg, rd);
      // Random controller bits and line level, so a lane mix-up shows in the counts
      {tx, bv} = rnd[19:16];
      ctrl_tx_data <= tx;
      i_scr_line_model.run(32, 4, bv);
      // Cleared mask bits drop out only in digital link and GCI modes
      n1 = (m >= 2) ? $countones(mk[7:0]) : 8;
      n2 = (m >= 2) ? $countones(mk[15:8]) : 8;
      e = '{0, 0, 0};
      k = dest(i / 4, cfg);
      if (m != 0 && k >= 0) e[k] += 2;
      k = dest(r1, cfg);
      if (m != 0 && k >= 0) e[k] += n1;
      k = dest(r2, cfg);
      if (m != 0 && k >= 0) e[k] += n2;
      s1 = (m == 0) ? 0 : (cfg[`SCR_STROBE_CTRL_B1_BIT] ? 0 : 8) + (cfg[`SCR_STROBE_CTRL_B2_BIT] ? 8 : 0);
      cmp_cnt("strobe one", s1, i_scr_line_model.cnt_s1);
      cmp_cnt("strobe two", (m == 0) ? 0 : 16 - s1, i_scr_line_model.cnt_s2);
      for (k = 0; k < 3; k++)
      begin
        cmp_cnt("lane valid", e[k], i_scr_line_model.cnt_v[k]);
        cmp_cnt("lane ones", bv ? e[k] : 0, i_scr_line_model.cnt_d[k]);
      end
      // Only routed bits of a controller that sends a one show on the line
      etx = e[0] * tx[0] + e[1] * tx[1] + e[2] * tx[2];
      cmp_cnt("tx ones", etx, i_scr_line_model.cnt_tx);
    end
    // One frame counted per sync pulse, one pulse per scenario
    axi_rd(STAT_BYTE, rd, rs);
    cmp_reg("frame count", 16, rd);
    give_verdict();
  end
endmodule
